// File: logic/edge_sync.v
`timescale 1ns/1ps
// three-stage synchroniser: edge reported when stages two and three differ
module edge_sync (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // pin in, synced level and edge out
  input wire pin_in,
  output wire level,
  output wire toggle
);
  reg [2:0] sync_r;
  // stage 0 only feeds stage 1
  always @(posedge mclk) begin
    if (!reset_n) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end
  // level taken straight from stage three, whatever stage two holds
  assign level = sync_r[2];
  assign toggle = sync_r[1] ^ sync_r[2];
endmodule // edge_sync

// File: logic/idle_power_map.vh
`ifndef IDLE_POWER_MAP_VH
`define IDLE_POWER_MAP_VH
// clock rate
`define CLK_HZ 40000000
// timing figures as printed, in their own unit
`define IDLE_TIME_S 30
`define SUPPLY_SETTLE_US 50
`define STATUS_FALL_US 30
`define STATUS_RISE_NS 400
`define WAKE_TIME_US 100
// derived cycle counts (longest rounds down, least rounds up)
`define IDLE_CYCLES (`IDLE_TIME_S * `CLK_HZ)
`define SETTLE_CYCLES ((`SUPPLY_SETTLE_US * `CLK_HZ) / 1000000)
`define FALL_CYCLES ((`STATUS_FALL_US * `CLK_HZ) / 1000000)
`define RISE_CYCLES ((`STATUS_RISE_NS * (`CLK_HZ / 1000) + 999999) / 1000000)
`define WAKE_CYCLES ((`WAKE_TIME_US * `CLK_HZ) / 1000000)
// register map
`define ADDR_STATUS 4'h0
`define ADDR_MASK 4'h4
`define ADDR_STATE 4'h8
`define EVT_SLEEP 0
`define EVT_WAKE 1
`define EVT_LINE_LOST 2
`define EVT_READY 3
`define EVT_BITS 4
`endif

// File: logic/transceiver_idle_power_control.v
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "idle_power_map.vh"
module transceiver_idle_power_control #(
  parameter NUM_TX = 2,
  parameter NUM_RX = 2,
  parameter IDLE_CYCLES = `IDLE_CYCLES,
  parameter SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter FALL_CYCLES = `FALL_CYCLES,
  parameter RISE_CYCLES = `RISE_CYCLES,
  parameter WAKE_CYCLES = `WAKE_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // mode pins
  input wire auto_mode_select_n,
  input wire force_powerdown_n,
  // logic side
  input wire [NUM_TX-1:0] logic_transmit_input,
  output reg [NUM_RX-1:0] logic_receive_output,
  // line side, receive levels already sliced by the analog front end
  input wire [NUM_RX-1:0] line_receive_input,
  input wire [NUM_RX-1:0] line_level_valid,
  output reg [NUM_TX-1:0] line_transmit_output,
  output reg [NUM_TX-1:0] line_transmit_oe,
  // power and status
  output reg pump_enable,
  input wire neg_rail_ok,
  output reg ready,
  output reg line_valid,
  output reg powered,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg irq
);
  // one-hot power states; the state register is read back as is,
  // so software sees the same codes as the state machine uses
  localparam ST_OFF = 4'h1;
  localparam ST_WAKE = 4'h2;
  localparam ST_ON = 4'h4;
  localparam ST_IDLE = 4'h8;
  localparam CW = 32;

  wire [NUM_TX-1:0] tx_lvl;
  wire [NUM_TX-1:0] tx_tog;
  wire [NUM_RX-1:0] rx_lvl;
  wire [NUM_RX-1:0] rx_tog;
  wire [NUM_RX-1:0] rv_lvl;
  wire auto_mode_select_n_lvl;
  wire auto_mode_select_n_tog;
  wire force_powerdown_n_lvl;
  wire force_powerdown_n_tog;
  wire ready_lvl;
  wire ready_tog;

  // one synchroniser per pin outside the register port
  // every pin outside the register port is asynchronous to mclk, so each passes three flops;
  // the toggle output is what the activity detector listens to
  // costs three cycles of latency, far below any documented delay
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TX; gi = gi + 1) begin : g_tx
      edge_sync u_tx (
        .mclk(mclk), .reset_n(reset_n),
        .pin_in(logic_transmit_input[gi]),
        .level(tx_lvl[gi]), .toggle(tx_tog[gi])
      );
    end
    for (gi = 0; gi < NUM_RX; gi = gi + 1) begin : g_rx
      edge_sync u_rx (
        .mclk(mclk), .reset_n(reset_n),
        .pin_in(line_receive_input[gi]),
        .level(rx_lvl[gi]), .toggle(rx_tog[gi])
      );
      edge_sync u_rv (
        .mclk(mclk), .reset_n(reset_n),
        .pin_in(line_level_valid[gi]),
        .level(rv_lvl[gi]), .toggle()
      );
    end
  endgenerate

  edge_sync u_auto_mode_select_n (
    .mclk(mclk), .reset_n(reset_n), .pin_in(auto_mode_select_n),
    .level(auto_mode_select_n_lvl), .toggle(auto_mode_select_n_tog)
  );
  edge_sync u_force_powerdown_n (
    .mclk(mclk), .reset_n(reset_n), .pin_in(force_powerdown_n),
    .level(force_powerdown_n_lvl), .toggle(force_powerdown_n_tog)
  );
  edge_sync u_rdy (
    .mclk(mclk), .reset_n(reset_n), .pin_in(neg_rail_ok),
    .level(ready_lvl), .toggle(ready_tog)
  );

  // any transition on any transmit or receive data input; levels play no part
  // a live but static line therefore lets the block fall asleep,
  // which is intended: in auto mode only data movement keeps the drivers on
  // edge only activity
  wire activity = (|tx_tog) | (|rx_tog);
  wire any_valid = |rv_lvl;

  // line_valid filter: slow fall, fast rise
  // the counter restarts whenever the raw level agrees again, so a
  // short dropout shorter than the fall time never reaches status
  // limitation: a chattering line may hold status at its old value
  reg [CW-1:0] vcnt_r;
  always @(posedge mclk) begin
    if (!reset_n) begin
      vcnt_r <= {CW{1'b0}};
      line_valid <= 1'b0;
    end else if (any_valid == line_valid) begin
      vcnt_r <= {CW{1'b0}};
    end else if (line_valid && vcnt_r >= FALL_CYCLES - 1) begin
      line_valid <= 1'b0;
      vcnt_r <= {CW{1'b0}};
    end else if (!line_valid && vcnt_r >= RISE_CYCLES - 1) begin
      line_valid <= 1'b1;
      vcnt_r <= {CW{1'b0}};
    end else begin
      vcnt_r <= vcnt_r + 1'b1;
    end
  end

  // power state machine
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg [CW-1:0] wake_tgt;
  reg from_idle_r;
  reg from_idle_nxt;
  // one shared counter times the rail settle, the wake and the idle
  // span; only one of them can run at a time, so one adder suffices
  // forced shutdown is checked first in every state so that it wins
  // over activity and over the mode select
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    from_idle_nxt = from_idle_r;
    // settle time from forced shutdown, wake time from idle sleep
    if (from_idle_r) begin
      wake_tgt = WAKE_CYCLES;
    end else begin
      wake_tgt = SETTLE_CYCLES;
    end
    case (state_r)
      ST_OFF: begin
        if (force_powerdown_n_lvl) begin
          state_nxt = ST_WAKE;
          cnt_nxt = {CW{1'b0}};
          from_idle_nxt = 1'b0;
        end
      end
      ST_WAKE: begin
        // pumps run here, drivers stay floating until the settle or wake count runs out
        // rails settle before driving
        if (!force_powerdown_n_lvl) begin
          state_nxt = ST_OFF;
        end else if (cnt_r >= wake_tgt - 1) begin
          state_nxt = ST_ON;
          cnt_nxt = {CW{1'b0}};
          from_idle_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_ON: begin
        // full power; the counter measures the quiet span
        if (!force_powerdown_n_lvl) begin
          state_nxt = ST_OFF;
        end else if (auto_mode_select_n_lvl || activity) begin
          cnt_nxt = {CW{1'b0}};
        end else if (cnt_r >= IDLE_CYCLES - 1) begin
          state_nxt = ST_IDLE;
          cnt_nxt = {CW{1'b0}};
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_IDLE: begin
        // low power; receivers still run so edges can be seen
        if (!force_powerdown_n_lvl) begin
          state_nxt = ST_OFF;
        // any edge wakes
        // a raised select also wakes, which a looped status relies on
        end else if (activity || auto_mode_select_n_lvl) begin
          state_nxt = ST_WAKE;
          cnt_nxt = {CW{1'b0}};
          from_idle_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_OFF;
        cnt_nxt = {CW{1'b0}};
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ST_OFF;
      cnt_r <= {CW{1'b0}};
      from_idle_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      from_idle_r <= from_idle_nxt;
    end
  end

  // auto mode gates the idle path
  wire on_nxt = (state_nxt == ST_ON);
  wire pump_nxt = (state_nxt == ST_WAKE) | (state_nxt == ST_ON);

  // pins: pumps, drivers, ready, receivers
  // pumps, drivers enable, ready and powered are registered from the next state, so they change
  // in the same cycle as the state register and never glitch
  // the receive path is not gated by any power state
  always @(posedge mclk) begin
    if (!reset_n) begin
      pump_enable <= 1'b0;
      line_transmit_oe <= {NUM_TX{1'b0}};
      line_transmit_output <= {NUM_TX{1'b0}};
      logic_receive_output <= {NUM_RX{1'b0}};
      ready <= 1'b0;
      powered <= 1'b0;
    end else begin
      pump_enable <= pump_nxt;
      line_transmit_oe <= {NUM_TX{on_nxt}};
      // inverting drivers
      line_transmit_output <= ~tx_lvl;
      logic_receive_output <= ~rx_lvl;
      ready <= pump_nxt & ready_lvl;
      powered <= on_nxt;
    end
  end

  // events and register port
  // each event is a one-cycle pulse from the state machine, the filter or the rail synchroniser
  // sleep covers both forced and idle power-down
  reg [`EVT_BITS-1:0] evt_r;
  reg [`EVT_BITS-1:0] mask_r;
  wire [`EVT_BITS-1:0] evt_in;
  assign evt_in[`EVT_SLEEP] = (state_r != ST_OFF) & (state_nxt == ST_OFF)
    | (state_r == ST_ON) & (state_nxt == ST_IDLE);
  assign evt_in[`EVT_WAKE] = (state_r != ST_ON) & on_nxt;
  // invalid line reported as event, in the cycle status falls
  assign evt_in[`EVT_LINE_LOST] = line_valid & ~any_valid
    & (vcnt_r >= FALL_CYCLES - 1);
  assign evt_in[`EVT_READY] = ready_tog & ready_lvl;
  wire wr_st = reg_wr & (reg_addr == `ADDR_STATUS);
  wire wr_mk = reg_wr & (reg_addr == `ADDR_MASK);

  // set wins over write-one-to-clear
  // irq is computed from the next status and mask so that it moves
  // in the same cycle as the registers it reflects
  always @(posedge mclk) begin
    if (!reset_n) begin
      evt_r <= {`EVT_BITS{1'b0}};
      mask_r <= {`EVT_BITS{1'b0}};
      irq <= 1'b0;
    end else begin
      evt_r <= (evt_r & ~({`EVT_BITS{wr_st}} & reg_wdata[`EVT_BITS-1:0]))
        | evt_in;
      if (wr_mk) begin
        mask_r <= reg_wdata[`EVT_BITS-1:0];
      end
      irq <= |(((evt_r & ~({`EVT_BITS{wr_st}} & reg_wdata[`EVT_BITS-1:0]))
        | evt_in) & (wr_mk ? reg_wdata[`EVT_BITS-1:0] : mask_r));
    end
  end

  // read data one cycle after the strobe, zero otherwise
  // unmapped addresses read as zero; the state word holds both
  // synced mode pins so software can see what the block acts on
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_STATUS: reg_rdata <= {4'h0, evt_r};
        `ADDR_MASK: reg_rdata <= {4'h0, mask_r};
        `ADDR_STATE: reg_rdata <= {line_valid, ready, force_powerdown_n_lvl, auto_mode_select_n_lvl,
          state_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // transceiver_idle_power_control

// File: sim/cable_far_end.sv
`timescale 1ns/1ps
// cable and rail comparator on the line side of the block
module cable_far_end #(
  parameter NUM_RX = 2,
  parameter RAIL_DELAY = 6
) (
  // clock and commands
  input wire mclk,
  input wire plugged,
  input wire [NUM_RX-1:0] rx_bits,
  // block side
  input wire pump_enable,
  output logic [NUM_RX-1:0] line_receive_input,
  output logic [NUM_RX-1:0] line_level_valid,
  output logic neg_rail_ok
);
  int rail_r = 0;
  // unplugged lines sag to ground via the pull-down
  assign line_receive_input = plugged ? rx_bits : '0;
  assign line_level_valid = {NUM_RX{plugged}};
  // rail crosses threshold a while after pumps start
  always @(posedge mclk) begin
    rail_r <= !pump_enable ? 0 : (rail_r < RAIL_DELAY ? rail_r + 1 : rail_r);
  end
  assign neg_rail_ok = rail_r >= RAIL_DELAY;
endmodule // cable_far_end

// File: sim/idle_power_props.sv
`timescale 1ns/1ps
// pin-level checks; helper counters time quiet and invalid spans
module idle_power_props #(
  parameter NUM_TX = 2,
  parameter NUM_RX = 2,
  parameter IDLE_CYCLES = 100,
  parameter FALL_CYCLES = 30
) (
  // clock and reset
  input logic mclk,
  input logic reset_n,
  // inputs
  input logic auto_mode_select_n,
  input logic force_powerdown_n,
  input logic [NUM_TX-1:0] logic_transmit_input,
  input logic [NUM_RX-1:0] line_receive_input,
  input logic [NUM_RX-1:0] line_level_valid,
  input logic neg_rail_ok,
  input logic reg_rd,
  // outputs
  input logic [NUM_RX-1:0] logic_receive_output,
  input logic [NUM_TX-1:0] line_transmit_oe,
  input logic pump_enable,
  input logic ready,
  input logic line_valid,
  input logic powered,
  input logic [7:0] reg_rdata
);
  int quiet_r;
  int inv_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // quiet span only counts while powered in auto mode
  always @(posedge mclk) begin
    if (!reset_n || !powered || auto_mode_select_n ||
        $changed(logic_transmit_input) || $changed(line_receive_input))
      quiet_r <= 0;
    else
      quiet_r <= quiet_r + 1;
  end
  // saturates so the hold check stays cheap
  always @(posedge mclk) begin
    if (!reset_n || |line_level_valid)
      inv_r <= 0;
    else if (inv_r < FALL_CYCLES + 8)
      inv_r <= inv_r + 1;
  end
  oe_pump_a: assert property (|line_transmit_oe |-> pump_enable)
    else $error("transmit enabled without pump");
  force_powerdown_n_force_a: assert property (!force_powerdown_n [*7] |->
    !pump_enable && line_transmit_oe == '0) else $error("not shut down");
  forced_on_a: assert property (
    (auto_mode_select_n && force_powerdown_n) [*8] ##1 !powered |->
    ##[1:30] powered) else $error("forced on did not power up");
  ready_rail_a: assert property (!neg_rail_ok [*6] |-> !ready)
    else $error("ready without rail");
  wake_edge_a: assert property (force_powerdown_n [*8] ##1
    ($changed(logic_transmit_input) || $changed(line_receive_input)) |->
    ##[1:8] (pump_enable || !force_powerdown_n)) else $error("no wake");
  sleep_late_a: assert property (powered |->
    quiet_r <= IDLE_CYCLES + 8) else $error("idle sleep too late");
  sleep_early_a: assert property ($fell(powered) &&
    force_powerdown_n && $past(force_powerdown_n, 8) |->
    quiet_r >= IDLE_CYCLES - 4) else $error("idle sleep too early");
  rx_follow_a: assert property ($stable(line_receive_input) [*6] |->
    logic_receive_output == ~line_receive_input) else $error("rx stale");
  valid_rise_a: assert property (|line_level_valid [*8] |->
    line_valid) else $error("line valid late");
  valid_fall_a: assert property ($fell(line_valid) |->
    inv_r >= FALL_CYCLES) else $error("line valid fell early");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
endmodule // idle_power_props

bind transceiver_idle_power_control idle_power_props #(.NUM_TX(NUM_TX),
  .NUM_RX(NUM_RX), .IDLE_CYCLES(IDLE_CYCLES), .FALL_CYCLES(FALL_CYCLES))
  u_props (.*);

// File: sim/transceiver_idle_power_control_test.sv
`timescale 1ns/1ps
`include "idle_power_map.vh"
module transceiver_idle_power_control_test;
  // stimulus
  logic mclk = 0, reset_n = 0, auto_mode_select_n = 1, force_powerdown_n = 0;
  logic [1:0] logic_transmit_input = '0, rx_bits = '0;
  logic plugged = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic loop_one = 0, loop_both = 0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  // observed
  wire [1:0] logic_receive_output, line_receive_input, line_level_valid;
  wire [1:0] line_transmit_output, line_transmit_oe;
  wire pump_enable, neg_rail_ok, ready, line_valid, powered, irq;
  wire [7:0] reg_rdata;
  logic [15:0] notes[$];
  logic [15:0] note;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // short counts keep the run brief
  transceiver_idle_power_control #(.IDLE_CYCLES(100), .SETTLE_CYCLES(20),
    .FALL_CYCLES(30), .RISE_CYCLES(1), .WAKE_CYCLES(20))
    u_transceiver_idle_power_control (.mclk(mclk), .reset_n(reset_n),
    .auto_mode_select_n((loop_one | loop_both) ? line_valid :
      auto_mode_select_n),
    .force_powerdown_n(loop_both ? line_valid : force_powerdown_n),
    .logic_transmit_input(logic_transmit_input),
    .logic_receive_output(logic_receive_output),
    .line_receive_input(line_receive_input),
    .line_level_valid(line_level_valid),
    .line_transmit_output(line_transmit_output),
    .line_transmit_oe(line_transmit_oe), .pump_enable(pump_enable),
    .neg_rail_ok(neg_rail_ok), .ready(ready), .line_valid(line_valid),
    .powered(powered), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  cable_far_end u_cable_far_end (.mclk(mclk), .plugged(plugged),
    .rx_bits(rx_bits), .pump_enable(pump_enable),
    .line_receive_input(line_receive_input),
    .line_level_valid(line_level_valid), .neg_rail_ok(neg_rail_ok));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read notes expected value under a mask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back({m, e});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // answer stands the cycle after the read only
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      note = notes.pop_front();
      check(reg_rdata & note[15:8], note[7:0]);
    end
  end
  // hang guard well beyond the planned sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h1663));
    idle(8);
    reset_n <= 1'b1;
    idle(4);
    rd(`ADDR_STATE, 8'h01, 8'h8f);
    force_powerdown_n <= 1'b1;
    repeat (40) begin
      @(posedge mclk);
      logic_transmit_input <= 2'($urandom);
    end
    rd(`ADDR_STATE, 8'h44, 8'hcf);
    plugged <= 1'b1;
    rx_bits <= 2'h3;
    idle(12);
    rd(`ADDR_STATE, 8'hc4, 8'hcf);
    $display("test forced modes done");
    // live but static line must not hold it awake
    auto_mode_select_n <= 1'b0;
    idle(120);
    rd(`ADDR_STATE, 8'h88, 8'hcf);
    for (int i = 0; i < 2; i++) begin
      if (i == 0)
        logic_transmit_input <= ~logic_transmit_input;
      else
        rx_bits <= ~rx_bits;
      idle(40);
      rd(`ADDR_STATE, 8'hc4, 8'hcf);
      idle(120);
      rd(`ADDR_STATE, 8'h88, 8'hcf);
    end
    $display("test auto mode done");
    plugged <= 1'b0;
    idle(20);
    rd(`ADDR_STATE, 8'h80, 8'h80);
    idle(20);
    rd(`ADDR_STATE, 8'h08, 8'h8f);
    $display("test line loss done");
    wr(`ADDR_MASK, 8'h00);
    rd(`ADDR_STATUS, 8'h0f, 8'hff);
    check({7'h0, irq}, 8'h00);
    wr(`ADDR_MASK, 8'h04);
    idle(2);
    #1 check({7'h0, irq}, 8'h01);
    wr(`ADDR_STATUS, 8'h0f);
    idle(2);
    #1 check({7'h0, irq}, 8'h00);
    rd(`ADDR_STATUS, 8'h00, 8'hff);
    rd(4'hc, 8'h00, 8'hff);
    $display("test interrupts done");
    auto_mode_select_n <= 1'b1;
    idle(40);
    rd(`ADDR_STATE, 8'h04, 8'h0f);
    force_powerdown_n <= 1'b0;
    idle(8);
    rd(`ADDR_STATE, 8'h01, 8'h4f);
    $display("test forced shutdown done");
    // status looped to both pins: off while the line is dead
    loop_both <= 1'b1;
    idle(8);
    rd(`ADDR_STATE, 8'h01, 8'h8f);
    plugged <= 1'b1;
    idle(40);
    rd(`ADDR_STATE, 8'h84, 8'h8f);
    // status looped to select only: sleeps when dead and quiet
    force_powerdown_n <= 1'b1;
    loop_both <= 1'b0;
    loop_one <= 1'b1;
    plugged <= 1'b0;
    idle(160);
    rd(`ADDR_STATE, 8'h08, 8'h8f);
    plugged <= 1'b1;
    idle(40);
    rd(`ADDR_STATE, 8'h84, 8'h8f);
    $display("test status loop done");
    idle(4);
    give_verdict();
  end
endmodule // transceiver_idle_power_control_test
